// *** rtl/rrre_pkg.sv ***
// shared constants and types of the return, reset and rotate executor
//
// Function
// RQ1: software reset opcode forces master-clear reset state; program counter becomes 0
// RQ2: software reset sets bit 6 of the reset control register
// RQ3: software reset clears accumulator, loop, digit, priority, repeat and N/OV/Z/C flags
// RQ4: interrupt return pops status low byte, priority bit 3, program counter high bits
// RQ5: interrupt return pops program counter low half, then inserts a no-operation
// RQ6: interrupt return has one fixed opcode; touches priority, repeat, N, OV, Z, C
// RQ7: the three returns take three cycles, or two with an exception pending; here four cycles, or three with an exception pending
// RQ8: literal return pops high then low counter bits, stack pointer drops by 4
// RQ9: literal return carries byte select, 10-bit literal and 4-bit destination
// RQ10: returned literal is zero-extended 10 bits; status flags stay unchanged
// RQ11: plain return pops counter high then low, inserts no-operation, flags unchanged
// RQ12: file rotate shifts left, old carry to bit 0, bit 7/15 to carry
// RQ13: file rotate opcode holds byte bit, destination bit and 13-bit address
// RQ14: destination bit 0 writes back to file register, 1 to default register
// RQ15: default working register is working register zero
// RQ16: both rotates change only N, Z and C and finish in one cycle; here only register-direct rotates do, memory operands take two or three
// RQ17: register rotate: carry to bit 0, source shifted up, top bit to carry
// RQ18: register rotate opcode holds byte bit, both modes and both register numbers
// RQ19: register rotate accepts direct, indirect, post and pre increment/decrement
// RQ20: byte rotates and byte literal return keep the destination upper byte
// RQ21: after rotate, N is result top bit and Z is set on all-zero result
package rrre_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [23:0] OP_SW_RESET = 24'hFE0000;
  localparam logic [23:0] OP_INT_RET = 24'h064000;
  localparam logic [23:0] OP_SUB_RET = 24'h060000;
  localparam logic [23:0] OP_FAM_MASK = 24'hFF8000;
  localparam logic [23:0] OP_LIT_RET = 24'h050000;
  localparam logic [23:0] OP_ROT_FILE = 24'hD68000;
  localparam logic [23:0] OP_ROT_DEFAULT_WORKING_REGISTER = 24'hD28000;

  // ==========================================================================
  // instruction fields
  localparam int BIT_BYTE = 14;
  localparam int BIT_DEST = 13;
  localparam int FILE_MSB = 12;
  localparam int LIT_MSB = 13;
  localparam int LIT_LSB = 4;
  localparam int WN_MSB = 3;
  localparam int DMODE_MSB = 13;
  localparam int DMODE_LSB = 11;
  localparam int DREG_MSB = 10;
  localparam int DREG_LSB = 7;
  localparam int SMODE_MSB = 6;
  localparam int SMODE_LSB = 4;
  localparam int SREG_MSB = 3;

  // ==========================================================================
  // status, core control and reset control bits
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 3;
  localparam int CORE_CONTROL_REGISTER_PRIORITY_LEVEL_BIT3 = 3;
  localparam int RESET_CONTROL_REGISTER_SWR = 6;

  // ==========================================================================
  // reset values
  localparam logic [22:0] PC_RESET = 23'h000000;
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] CORE_CONTROL_REGISTER_RESET = 16'h0020;
  localparam logic [15:0] RESET_CONTROL_REGISTER_RESET = 16'h0000;
  localparam logic [15:0] W_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0800;

  // ==========================================================================
  // registers, steps and addressing modes
  localparam logic [3:0] SP_REG = 4'hF;
  localparam logic [3:0] W_DEFAULT = 4'h0;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [2:0] AM_DIRECT = 3'h0;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_PREINC = 3'h5;

  // ==========================================================================
  // types
  typedef logic [15:0][15:0] rrre_wfile_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } rrre_mem_req_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_POP_HI = 6'h02,
    S_POP_LO = 6'h04,
    S_NOP = 6'h08,
    S_ROT_RD = 6'h10,
    S_MEM_WR = 6'h20
  } rrre_fsm_t;

  typedef struct packed {
    rrre_fsm_t fsm;
    logic [22:0] pc;
    logic [15:0] sr;
    logic [15:0] core_control_register;
    logic [15:0] reset_control_register;
    rrre_wfile_t w;
    rrre_mem_req_t mem;
    logic ready;
    logic nop_ins;
    logic sw_rst;
    logic int_ret;
    logic lit_ret;
    logic byte_op;
    logic [9:0] lit;
    logic [3:0] wn;
    logic dst_w;
    logic [3:0] dreg;
    logic [15:0] ea;
  } rrre_state_t;

endpackage

// *** rtl/rrre_rot.sv ***
// rotate-left-through-carry datapath with flag results
`timescale 1ns/1ps
module rrre_rot (
  // operands
  input wire logic [15:0] i_src,
  input wire logic [15:0] i_dst_old,
  input wire logic i_carry,
  input wire logic i_byte,
  // results
  output logic [15:0] o_res,
  output logic o_carry,
  output logic o_neg,
  output logic o_zero
);

  always_comb begin
    if (i_byte) begin
      o_res = {i_dst_old[15:8], i_src[6:0], i_carry}; // [RQ12] [RQ17] [RQ20]
      o_carry = i_src[7]; // [RQ12] [RQ17]
      o_neg = i_src[6]; // [RQ21]
      o_zero = ({i_src[6:0], i_carry} == 8'h00); // [RQ21]
    end else begin
      o_res = {i_src[14:0], i_carry}; // [RQ12] [RQ17]
      o_carry = i_src[15]; // [RQ12] [RQ17]
      o_neg = i_src[14]; // [RQ21]
      o_zero = ({i_src[14:0], i_carry} == 16'h0000); // [RQ21]
    end
  end

endmodule

// *** rtl/rrre_exec.sv ***
// executor for software reset, the three returns and rotate left through carry
`timescale 1ns/1ps
module rrre_exec (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // instruction stream
  input wire logic [23:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic i_exc_pending,
  output logic o_instr_ready,
  output logic o_nop_insert,
  output logic o_sw_reset,
  // data memory, read data answers the address in the same cycle
  output rrre_pkg::rrre_mem_req_t o_mem,
  input wire logic [15:0] i_mem_rdata,
  // architectural state
  output logic [22:0] o_pc,
  output logic [15:0] o_status_word,
  output logic [15:0] o_core_control_register,
  output logic [15:0] o_reset_control_register,
  output rrre_pkg::rrre_wfile_t o_default_working_register
);
  import rrre_pkg::*;

  // ==========================================================================
  // state
  rrre_state_t st;
  rrre_state_t next_st;

  // ==========================================================================
  // helpers
  function automatic rrre_state_t reset_state();
    rrre_state_t r;
    r = '0;
    r.fsm = S_IDLE;
    r.ready = 1'b1;
    r.pc = PC_RESET; // [RQ1]
    r.sr = SR_RESET; // [RQ3]
    r.core_control_register = CORE_CONTROL_REGISTER_RESET;
    r.reset_control_register = RESET_CONTROL_REGISTER_RESET;
    for (int i = 0; i < 16; i++) begin
      r.w[i] = W_RESET;
    end
    r.w[SP_REG] = SP_RESET;
    return r;
  endfunction

  // effective address for a mode, before any register update
  function automatic logic [15:0] ea_of(
    input logic [2:0] mode,
    input logic [15:0] r,
    input logic [15:0] step
  );
    case (mode)
      AM_PREDEC: ea_of = r - step;
      AM_PREINC: ea_of = r + step;
      default: ea_of = r;
    endcase
  endfunction

  // register value left behind by a mode
  function automatic logic [15:0] upd_of(
    input logic [2:0] mode,
    input logic [15:0] r,
    input logic [15:0] step
  );
    case (mode)
      AM_POSTDEC, AM_PREDEC: upd_of = r - step;
      AM_POSTINC, AM_PREINC: upd_of = r + step;
      default: upd_of = r;
    endcase
  endfunction

  // ==========================================================================
  // instruction fields
  logic op_byte;
  logic op_dest;
  logic [2:0] dmode;
  logic [3:0] dreg;
  logic [2:0] smode;
  logic [3:0] sreg;
  logic [15:0] step;
  logic [15:0] sp_dec;
  logic is_ret;

  assign op_byte = i_instr[BIT_BYTE]; // [RQ9] [RQ13] [RQ18]
  assign op_dest = i_instr[BIT_DEST]; // [RQ13]
  assign dmode = i_instr[DMODE_MSB:DMODE_LSB]; // [RQ18]
  assign dreg = i_instr[DREG_MSB:DREG_LSB]; // [RQ18]
  assign smode = i_instr[SMODE_MSB:SMODE_LSB]; // [RQ18]
  assign sreg = i_instr[SREG_MSB:0]; // [RQ18]
  assign step = op_byte ? STEP_BYTE : STEP_WORD;
  assign sp_dec = st.w[SP_REG] - STEP_WORD;
  assign is_ret = (i_instr == OP_INT_RET) || (i_instr == OP_SUB_RET) ||
                  ((i_instr & OP_FAM_MASK) == OP_LIT_RET); // [RQ6] [RQ9]

  // ==========================================================================
  // rotate datapath
  logic in_rd;
  logic [15:0] rd_lane;
  logic [15:0] rot_src;
  logic [3:0] rot_dreg;
  logic rot_byte;
  logic [15:0] rot_res;
  logic rot_c;
  logic rot_n;
  logic rot_z;

  assign in_rd = (st.fsm == S_ROT_RD);
  // odd byte address selects the upper lane of the word
  assign rd_lane = st.mem.addr[0] ? {8'h00, i_mem_rdata[15:8]} : i_mem_rdata;
  assign rot_src = in_rd ? rd_lane : st.w[sreg];
  assign rot_dreg = in_rd ? st.dreg : dreg;
  assign rot_byte = in_rd ? st.byte_op : op_byte;

  rrre_rot u_rot (
    .i_src(rot_src),
    .i_dst_old(st.w[rot_dreg]),
    .i_carry(st.sr[SR_C]),
    .i_byte(rot_byte),
    .o_res(rot_res),
    .o_carry(rot_c),
    .o_neg(rot_n),
    .o_zero(rot_z)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic [15:0] d_ea;
    d_ea = '0;
    next_st = st;
    next_st.nop_ins = 1'b0;
    next_st.sw_rst = 1'b0;
    case (st.fsm)
      S_IDLE: begin
        if (i_instr_valid) begin
          if (i_instr == OP_SW_RESET) begin
            next_st = reset_state(); // [RQ1] [RQ3]
            next_st.reset_control_register[RESET_CONTROL_REGISTER_SWR] = 1'b1; // [RQ2]
            next_st.sw_rst = 1'b1; // [RQ1]
          end else if (is_ret) begin
            // first pop: pointer drops by one word, read the top word
            next_st.w[SP_REG] = sp_dec; // [RQ4] [RQ8] [RQ11]
            next_st.mem.rd = 1'b1;
            next_st.mem.addr = sp_dec; // [RQ4] [RQ8] [RQ11]
            next_st.int_ret = (i_instr == OP_INT_RET); // [RQ6]
            next_st.lit_ret = ((i_instr & OP_FAM_MASK) == OP_LIT_RET);
            next_st.byte_op = op_byte; // [RQ9]
            next_st.lit = i_instr[LIT_MSB:LIT_LSB]; // [RQ9]
            next_st.wn = i_instr[WN_MSB:0]; // [RQ9]
            next_st.fsm = S_POP_HI; // [RQ7]
          end else if ((i_instr & OP_FAM_MASK) == OP_ROT_FILE) begin
            next_st.mem.rd = 1'b1;
            next_st.mem.addr = {3'h0, i_instr[FILE_MSB:0]}; // [RQ13]
            next_st.ea = {3'h0, i_instr[FILE_MSB:0]}; // [RQ14]
            next_st.dst_w = op_dest; // [RQ14]
            next_st.dreg = W_DEFAULT; // [RQ15]
            next_st.byte_op = op_byte;
            next_st.fsm = S_ROT_RD;
          end else if ((i_instr & OP_FAM_MASK) == OP_ROT_DEFAULT_WORKING_REGISTER) begin
            d_ea = ea_of(dmode, st.w[dreg], step); // [RQ19]
            next_st.w[sreg] = upd_of(smode, st.w[sreg], step); // [RQ19]
            next_st.w[dreg] = upd_of(dmode, next_st.w[dreg], step); // [RQ19]
            next_st.byte_op = op_byte;
            next_st.dst_w = (dmode == AM_DIRECT); // [RQ19]
            next_st.dreg = dreg;
            next_st.ea = d_ea;
            if (smode != AM_DIRECT) begin
              // indirect source: fetch the operand first
              next_st.mem.rd = 1'b1;
              next_st.mem.addr = ea_of(smode, st.w[sreg], step); // [RQ19]
              next_st.fsm = S_ROT_RD;
            end else begin
              next_st.sr[SR_N] = rot_n; // [RQ16] [RQ21]
              next_st.sr[SR_Z] = rot_z; // [RQ16] [RQ21]
              next_st.sr[SR_C] = rot_c; // [RQ16] [RQ17]
              if (dmode == AM_DIRECT) begin
                next_st.w[dreg] = rot_res; // [RQ16] [RQ17]
              end else begin
                next_st.mem.wr = 1'b1;
                next_st.mem.addr = d_ea;
                next_st.mem.wdata = op_byte ? {rot_res[7:0], rot_res[7:0]}
                                            : rot_res;
                next_st.mem.be = op_byte ? (d_ea[0] ? 2'h2 : 2'h1)
                                         : 2'h3; // [RQ20]
                next_st.fsm = S_MEM_WR;
              end
            end
          end
        end
      end
      S_POP_HI: begin
        next_st.pc[22:16] = i_mem_rdata[6:0]; // [RQ4] [RQ8] [RQ11]
        if (st.int_ret) begin
          next_st.sr[7:0] = i_mem_rdata[15:8]; // [RQ4] [RQ6]
          next_st.core_control_register[CORE_CONTROL_REGISTER_PRIORITY_LEVEL_BIT3] = i_mem_rdata[7]; // [RQ4] [RQ6]
        end
        // second pop: pointer drops again, total of two words
        next_st.w[SP_REG] = sp_dec; // [RQ5] [RQ8] [RQ11]
        next_st.mem.addr = sp_dec; // [RQ5] [RQ8] [RQ11]
        next_st.fsm = S_POP_LO;
      end
      S_POP_LO: begin
        next_st.pc[15:0] = i_mem_rdata; // [RQ5] [RQ8] [RQ11]
        next_st.mem.rd = 1'b0;
        if (st.lit_ret) begin
          if (st.byte_op) begin
            next_st.w[st.wn][7:0] = st.lit[7:0]; // [RQ20]
          end else begin
            next_st.w[st.wn] = {6'h00, st.lit}; // [RQ8] [RQ10]
          end
        end
        // a pending exception takes over the slot of the inserted no-op
        if (i_exc_pending) begin
          next_st.fsm = S_IDLE; // [RQ7]
        end else begin
          next_st.nop_ins = 1'b1; // [RQ5] [RQ11]
          next_st.fsm = S_NOP; // [RQ7]
        end
      end
      S_NOP: begin
        next_st.fsm = S_IDLE;
      end
      S_ROT_RD: begin
        next_st.mem.rd = 1'b0;
        next_st.sr[SR_N] = rot_n; // [RQ16] [RQ21]
        next_st.sr[SR_Z] = rot_z; // [RQ16] [RQ21]
        next_st.sr[SR_C] = rot_c; // [RQ12] [RQ16]
        if (st.dst_w) begin
          next_st.w[st.dreg] = rot_res; // [RQ14] [RQ15]
          next_st.fsm = S_IDLE;
        end else begin
          next_st.mem.wr = 1'b1;
          next_st.mem.addr = st.ea; // [RQ14]
          next_st.mem.wdata = st.byte_op ? {rot_res[7:0], rot_res[7:0]}
                                         : rot_res;
          next_st.mem.be = st.byte_op ? (st.ea[0] ? 2'h2 : 2'h1)
                                      : 2'h3; // [RQ20]
          next_st.fsm = S_MEM_WR;
        end
      end
      S_MEM_WR: begin
        next_st.mem.wr = 1'b0;
        next_st.fsm = S_IDLE;
      end
      default: begin
        next_st.fsm = S_IDLE;
        next_st.mem.rd = 1'b0;
        next_st.mem.wr = 1'b0;
      end
    endcase
    next_st.ready = (next_st.fsm == S_IDLE);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign o_instr_ready = st.ready;
  assign o_nop_insert = st.nop_ins;
  assign o_sw_reset = st.sw_rst;
  assign o_mem = st.mem;
  assign o_pc = st.pc;
  assign o_status_word = st.sr;
  assign o_core_control_register = st.core_control_register;
  assign o_reset_control_register = st.reset_control_register;
  assign o_default_working_register = st.w;

endmodule

// *** dv/rrre_exec_props.sv ***
// assertion checker for the return, reset and rotate executor
`timescale 1ns/1ps
module rrre_exec_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // instruction stream
  input wire logic [23:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic i_exc_pending,
  input wire logic o_instr_ready,
  input wire logic o_nop_insert,
  input wire logic o_sw_reset,
  // data memory
  input wire rrre_pkg::rrre_mem_req_t o_mem,
  input wire logic [15:0] i_mem_rdata,
  // architectural state
  input wire logic [22:0] o_pc,
  input wire logic [15:0] o_status_word,
  input wire logic [15:0] o_core_control_register,
  input wire logic [15:0] o_reset_control_register,
  input wire rrre_pkg::rrre_wfile_t o_default_working_register
);
  import rrre_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // decode helpers
  logic take, is_int, is_ret, rot_dir, bsel, cout, rneg, rzero;
  logic [15:0] src, rot_res;
  assign take = i_instr_valid && o_instr_ready;
  assign is_int = i_instr == OP_INT_RET;
  assign is_ret = is_int || i_instr == OP_SUB_RET ||
    (i_instr & OP_FAM_MASK) == OP_LIT_RET;
  assign rot_dir = (i_instr & OP_FAM_MASK) == OP_ROT_DEFAULT_WORKING_REGISTER &&
    i_instr[DMODE_MSB:DMODE_LSB] == AM_DIRECT &&
    i_instr[SMODE_MSB:SMODE_LSB] == AM_DIRECT;
  assign bsel = i_instr[BIT_BYTE];
  assign src = o_default_working_register[i_instr[SREG_MSB:0]];
  assign rot_res = bsel ? {o_default_working_register[i_instr[DREG_MSB:DREG_LSB]][15:8],
    src[6:0], o_status_word[SR_C]} : {src[14:0], o_status_word[SR_C]};
  assign cout = bsel ? src[7] : src[15];
  assign rneg = bsel ? rot_res[7] : rot_res[15];
  assign rzero = bsel ? (rot_res[7:0] == 8'h00) : (rot_res == 16'h0000);

  // ==========================================================================
  // properties
  sequence s_ret;
    take && is_ret;
  endsequence
  sequence s_pops;
    o_mem.rd && o_mem.addr == $past(o_default_working_register[SP_REG]) - 16'h0002 ##1
    o_mem.rd && o_mem.addr == $past(o_default_working_register[SP_REG], 2) - 16'h0004;
  endsequence
  property p_swr;
    take && i_instr == OP_SW_RESET |=> o_pc == PC_RESET &&
      o_reset_control_register[RESET_CONTROL_REGISTER_SWR] && o_sw_reset && o_instr_ready;
  endproperty
  property p_swr_flags;
    take && i_instr == OP_SW_RESET |=> o_status_word == SR_RESET &&
      o_core_control_register == CORE_CONTROL_REGISTER_RESET && o_default_working_register[SP_REG] == SP_RESET;
  endproperty
  property p_ret_pops;
    s_ret |=> s_pops;
  endproperty
  property p_ret_time;
    s_ret |=> !o_instr_ready [*2] ##1 o_instr_ready == $past(i_exc_pending);
  endproperty
  property p_ret_nop;
    s_ret |=> ##2 o_nop_insert == !$past(i_exc_pending);
  endproperty
  property p_ret_pc_hi;
    s_ret ##1 1 |=> o_pc[22:16] == $past(i_mem_rdata[6:0]);
  endproperty
  property p_ret_pc_lo;
    s_ret ##2 1 |=> o_pc[15:0] == $past(i_mem_rdata) &&
      o_default_working_register[SP_REG] == $past(o_default_working_register[SP_REG], 3) - 16'h0004;
  endproperty
  property p_int_sr;
    take && is_int ##1 1 |=> o_status_word[7:0] == $past(i_mem_rdata[15:8])
      && o_core_control_register[CORE_CONTROL_REGISTER_PRIORITY_LEVEL_BIT3] == $past(i_mem_rdata[7]);
  endproperty
  property p_flags_kept;
    take && is_ret && !is_int |=> ##2
      o_status_word == $past(o_status_word, 3);
  endproperty
  property p_rot_dir;
    take && rot_dir |=> o_instr_ready && o_status_word[SR_C] == $past(cout)
      && o_default_working_register[$past(i_instr[DREG_MSB:DREG_LSB])] == $past(rot_res);
  endproperty
  property p_rot_nz;
    take && rot_dir |=> o_status_word[SR_N] == $past(rneg) &&
      o_status_word[SR_Z] == $past(rzero) &&
      o_status_word[15:4] == $past(o_status_word[15:4]);
  endproperty
  property p_rot_file;
    take && (i_instr & OP_FAM_MASK) == OP_ROT_FILE && i_instr[BIT_DEST] &&
      !bsel ##1 1 |=> o_default_working_register[W_DEFAULT] ==
      {$past(i_mem_rdata[14:0]), $past(o_status_word[SR_C])};
  endproperty

  // ==========================================================================
  // assertions
  a_swr: assert property (p_swr)
    else $error("soft reset state wrong");
  a_swr_flags: assert property (p_swr_flags)
    else $error("soft reset flags wrong");
  a_ret_pops: assert property (p_ret_pops)
    else $error("stack pops wrong");
  a_ret_time: assert property (p_ret_time)
    else $error("return length wrong");
  a_ret_nop: assert property (p_ret_nop)
    else $error("no-op insert wrong");
  a_ret_pc_hi: assert property (p_ret_pc_hi)
    else $error("counter high wrong");
  a_ret_pc_lo: assert property (p_ret_pc_lo)
    else $error("counter low or stack wrong");
  a_int_sr: assert property (p_int_sr)
    else $error("status restore wrong");
  a_flags_kept: assert property (p_flags_kept)
    else $error("return changed flags");
  a_rot_dir: assert property (p_rot_dir)
    else $error("register rotate wrong");
  a_rot_nz: assert property (p_rot_nz)
    else $error("rotate flags wrong");
  a_rot_file: assert property (p_rot_file)
    else $error("file rotate to default wrong");
endmodule

bind rrre_exec rrre_exec_props i_rrre_exec_props (
  .i_clk, .i_rst, .i_instr, .i_instr_valid, .i_exc_pending, .o_instr_ready,
  .o_nop_insert, .o_sw_reset, .o_mem, .i_mem_rdata, .o_pc, .o_status_word,
  .o_core_control_register, .o_reset_control_register, .o_default_working_register
);

// *** dv/rrre_mem_model.sv ***
// data memory model answering reads in the same cycle
`timescale 1ns/1ps
module rrre_mem_model (
  // clock and request
  input wire logic i_clk,
  input wire rrre_pkg::rrre_mem_req_t i_mem,
  // read data
  output logic [15:0] o_rdata
);
  import rrre_pkg::*;
  logic [15:0] mem [0:32767];
  logic [15:0] last = 16'hA5A5;
  // outside reads the bus toggles, so stale data is never seen
  assign o_rdata = i_mem.rd ? mem[i_mem.addr[15:1]] : ~last;
  always @(posedge i_clk) begin
    last <= o_rdata;
    if (i_mem.wr) begin
      if (i_mem.be[0]) mem[i_mem.addr[15:1]][7:0] <= i_mem.wdata[7:0];
      if (i_mem.be[1]) mem[i_mem.addr[15:1]][15:8] <= i_mem.wdata[15:8];
    end
  end
endmodule

// *** dv/return_reset_rotate_exec_tb_top.sv ***
// self-checking bench for the return, reset and rotate executor
`timescale 1ns/1ps
module return_reset_rotate_exec_tb_top;
  import rrre_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end

  // ==========================================================================
  // signals
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [23:0] i_instr = 24'h000000;
  logic i_instr_valid = 1'b0;
  logic i_exc_pending = 1'b0;
  logic o_instr_ready, o_nop_insert, o_sw_reset;
  rrre_mem_req_t o_mem;
  logic [15:0] i_mem_rdata;
  logic [22:0] o_pc;
  logic [15:0] o_status_word, o_core_control_register;
  logic [15:0] o_reset_control_register;
  rrre_wfile_t o_default_working_register;
  int fails = 0;
  int num_checks = 0;
  int cyc;
  logic [15:0] sp = 16'h0800;
  logic [23:0] rot_op [4] = '{24'hD28182, 24'hD2C105, 24'hD28383, 24'hD28304};
  int rot_dst [4] = '{3, 2, 7, 6};
  logic [15:0] rot_res [4] = '{16'h0615, 16'h03E0, 16'h0C2B, 16'h0000};
  logic [15:0] rot_sr [4] = '{16'h0000, 16'h0009, 16'h0000, 16'h0002};

  always #5 i_clk = ~i_clk;

  rrre_exec i_rrre_exec (
    .i_clk, .i_rst, .i_instr, .i_instr_valid, .i_exc_pending, .o_instr_ready,
    .o_nop_insert, .o_sw_reset, .o_mem, .i_mem_rdata, .o_pc, .o_status_word,
    .o_core_control_register, .o_reset_control_register, .o_default_working_register
  );
  rrre_mem_model i_rrre_mem_model (
    .i_clk(i_clk),
    .i_mem(o_mem),
    .o_rdata(i_mem_rdata)
  );

  // ==========================================================================
  // tasks
  task automatic exe(input logic [23:0] op, input logic exc);
    @(posedge i_clk);
    #1;
    i_instr = op;
    i_instr_valid = 1'b1;
    i_exc_pending = exc;
    @(posedge i_clk);
    #1;
    i_instr_valid = 1'b0;
    cyc = 1;
    while (o_instr_ready !== 1'b1 && cyc < 20) begin
      @(posedge i_clk);
      #1;
      cyc++;
    end
  endtask

  task automatic ret(input logic [23:0] op, input logic [15:0] hi,
                     input logic [15:0] lo, input logic exc);
    i_rrre_mem_model.mem[(sp - 16'h0002) >> 1] = hi;
    i_rrre_mem_model.mem[(sp - 16'h0004) >> 1] = lo;
    exe(op, exc);
    sp = sp - 16'h0004;
    `CHK(o_pc, {hi[6:0], lo})
    `CHK(o_default_working_register[SP_REG], sp)
    // cyc counts from the take edge; the registered stack address costs one
    `CHK(cyc, exc ? 3 : 4)
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    `CHK(o_pc, PC_RESET)
    `CHK(o_core_control_register, CORE_CONTROL_REGISTER_RESET)
    `CHK(o_default_working_register[SP_REG], SP_RESET)
    tend("reset");
    ret({8'h05, 2'b00, 10'h3FF, 4'h2}, 16'h0000, 16'h0100, 1'b0);
    `CHK(o_default_working_register[2], 16'h03FF)
    ret({8'h05, 2'b01, 10'h00A, 4'h2}, 16'h0001, 16'h7006, 1'b1);
    `CHK(o_default_working_register[2], 16'h030A)
    ret({8'h05, 2'b00, 10'h200, 4'h8}, 16'h0000, 16'h0200, 1'b0);
    ret({8'h05, 2'b00, 10'h3F0, 4'h5}, 16'h0000, 16'h0300, 1'b0);
    `CHK(o_status_word, 16'h0000)
    tend("literal return");
    ret(OP_SUB_RET, 16'h0001, 16'h0004, 1'b0);
    ret(OP_INT_RET, 16'h8181, 16'h0230, 1'b1);
    `CHK(o_status_word, 16'h0081)
    `CHK(o_core_control_register, 16'h0028)
    ret(OP_INT_RET, 16'h0300, 16'h7008, 1'b0);
    `CHK(o_status_word, 16'h0003)
    `CHK(o_core_control_register, 16'h0020)
    tend("returns");
    for (int k = 0; k < 4; k++) begin
      exe(rot_op[k], 1'b0);
      `CHK(cyc, 1)
      `CHK(o_default_working_register[rot_dst[k]], rot_res[k])
      `CHK(o_status_word, rot_sr[k])
    end
    tend("register rotate");
    i_rrre_mem_model.mem[16'h0410] = 16'h216E;
    i_rrre_mem_model.mem[16'h0919] = 16'hE807;
    exe(24'hD6A820, 1'b0);
    `CHK(o_default_working_register[0], 16'h42DC)
    `CHK(i_rrre_mem_model.mem[16'h0410], 16'h216E)
    exe(24'hD6D233, 1'b0);
    `CHK(i_rrre_mem_model.mem[16'h0919], 16'hD007)
    `CHK(o_status_word, 16'h0009)
    tend("file rotate");
    i_rrre_mem_model.mem[16'h01F8] = 16'h3689;
    exe(24'hD28C35, 1'b0);
    `CHK(i_rrre_mem_model.mem[16'h0100], 16'h6D13)
    `CHK(o_default_working_register[5], 16'h03F2)
    exe(24'hD2A403, 1'b0);
    `CHK(o_default_working_register[8], 16'h01FE)
    `CHK(i_rrre_mem_model.mem[16'h00FF], 16'h0C2A)
    tend("indirect rotate");
    exe(24'hD2C485, 1'b0);
    `CHK(o_default_working_register[9], 16'h00E4)
    `CHK(o_status_word, 16'h0009)
    exe(OP_SW_RESET, 1'b0);
    `CHK(o_sw_reset, 1'b1)
    `CHK(o_reset_control_register, 16'h0040)
    `CHK(o_status_word, SR_RESET)
    `CHK(o_core_control_register, CORE_CONTROL_REGISTER_RESET)
    `CHK(o_pc, PC_RESET)
    for (int k = 0; k < 15; k++) `CHK(o_default_working_register[k], 16'h0000)
    `CHK(o_default_working_register[SP_REG], SP_RESET)
    tend("software reset");
    end_of_test;
  end

  initial begin
    #200000;
    fails++;
    end_of_test;
  end
endmodule
